//--- bench/bomx_exec_asserts.sv
// Port-level assertions for the execution block.
`timescale 1ns/10ps
`default_nettype none
module bomx_exec_asserts (
    // Clock and reset.
    input wire logic               clk_sys,
    input wire logic               resetn,
    input wire logic               clkEn,
    // Issue.
    input wire logic               issue,
    input wire bomx_pkg::bomx_op_t opCode,
    input wire logic               destSel,
    input wire logic               pointerSel,
    input wire logic [1:0]         pointerUpdateMode,
    input wire logic               relativeForm,
    // Results.
    input wire logic               busy,
    input wire logic               done_q,
    input wire logic [7:0]         accumulator_q,
    input wire logic               zeroFlag_q,
    input wire logic               carryFlag_q,
    input wire logic [15:0]        pointer0_q,
    input wire logic [15:0]        pointer1_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Operands held from the edge that took the instruction.
    bomx_pkg::bomx_op_t opT_q;
    logic               dstT_q, selT_q, relT_q, downT_q, isLoad, isShift;
    always_ff @(posedge clk_sys)
    begin
        if (clkEn && issue && !busy)
        begin
            opT_q   <= opCode;
            dstT_q  <= destSel;
            selT_q  <= pointerSel;
            relT_q  <= relativeForm;
            downT_q <= pointerUpdateMode[0];
        end
    end
    assign isLoad  = (opT_q == bomx_pkg::OP_INDIRECT_LOAD_ACCUM);
    assign isShift = (opT_q == bomx_pkg::OP_LOGICAL_SHIFT_LEFT) || (opT_q == bomx_pkg::OP_LOGICAL_SHIFT_RIGHT);
    a_take_busy: assert property (clkEn && issue && !busy |=> busy)
        else $error("busy did not follow a taken issue");
    a_exec_done: assert property (clkEn && busy |=> !busy && done_q)
        else $error("execution did not end after one cycle");
    a_done_pulse: assert property (clkEn && done_q |=> !done_q)
        else $error("done stayed high");
    a_idle_hold: assert property (!busy |=> $stable(accumulator_q) && $stable(zeroFlag_q) && $stable(carryFlag_q))
        else $error("result changed while idle");
    a_carry_kept: assert property (busy && !isShift |=> $stable(carryFlag_q))
        else $error("carry changed by a non-shift instruction");
    a_zero_acc: assert property (done_q && (isLoad || !dstT_q) |-> zeroFlag_q == (accumulator_q == 8'h00))
        else $error("zero flag does not match accumulator");
    a_ptr_fixed: assert property (busy && !(isLoad && !relT_q) |=> $stable(pointer0_q) && $stable(pointer1_q))
        else $error("pointer changed without a stepping load");
    a_ptr_step: assert property (clkEn && busy && isLoad && !relT_q |=> (selT_q ? pointer1_q : pointer0_q) ==
        (selT_q ? $past(pointer1_q) : $past(pointer0_q)) + (downT_q ? 16'hFFFF : 16'h0001)
        && (selT_q ? $stable(pointer0_q) : $stable(pointer1_q)))
        else $error("pointer step wrong");
endmodule : bomx_exec_asserts
bind bomx_exec bomx_exec_asserts bomx_exec_asserts_i (.clk_sys, .resetn, .clkEn, .issue, .opCode, .destSel, .pointerSel,
    .pointerUpdateMode, .relativeForm, .busy, .done_q, .accumulator_q, .zeroFlag_q, .carryFlag_q,
    .pointer0_q, .pointer1_q);
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the byte-operation and indirect-load block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic               clk_sys = 1'b0, resetn = 1'b0, clkEn = 1'b1, issue = 1'b0, destSel = 1'b0;
    logic               pointerSel = 1'b0, relativeForm = 1'b0, pointerWrite = 1'b0, pointerWriteSel = 1'b0;
    logic               memWrite = 1'b0, busy, done_q, zeroFlag_q, carryFlag_q, expC = 1'b0;
    bomx_pkg::bomx_op_t opCode = bomx_pkg::OP_MOVE_REGISTER;
    logic [6:0]         regAddr = 7'h00;
    logic [1:0]         pointerUpdateMode = 2'h0;
    logic [5:0]         relativeOffset = 6'h00;
    logic [15:0]        pointerWriteData = 16'h0000, pointer0_q, pointer1_q;
    logic [7:0]         memWriteAddr = 8'h00, memWriteData = 8'h00, memPeekAddr = 8'h00;
    logic [7:0]         accumulator_q, memPeekData, expAcc = 8'h00;
    logic [7:0]         mem [256];
    int                 err_total = 0;
    int                 num_checks = 0;
    bomx_exec bomx_exec_i (.clk_sys, .resetn, .clkEn, .issue, .opCode, .regAddr, .destSel, .pointerSel,
        .pointerUpdateMode, .relativeForm, .relativeOffset, .pointerWrite, .pointerWriteSel,
        .pointerWriteData, .memWrite, .memWriteAddr, .memWriteData, .memPeekAddr, .busy, .done_q,
        .accumulator_q, .zeroFlag_q, .carryFlag_q, .pointer0_q, .pointer1_q, .memPeekData);
    always #4 clk_sys = ~clk_sys;
    task automatic summarize();
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task automatic chkv(input string nm, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chkv
    task automatic chkf(input string nm, input logic e, input logic s);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %s expected %b seen %b", nm, e, s);
        end
    endtask : chkf
    task automatic wmem(input logic [7:0] a, input logic [7:0] d);
        memWrite = 1'b1;
        memWriteAddr = a;
        memWriteData = d;
        mem[a] = d;
        @(negedge clk_sys);
        memWrite = 1'b0;
        @(negedge clk_sys);
    endtask : wmem
    task automatic wptr(input logic s, input logic [15:0] d);
        pointerWrite = 1'b1;
        pointerWriteSel = s;
        pointerWriteData = d;
        @(negedge clk_sys);
        pointerWrite = 1'b0;
        @(negedge clk_sys);
    endtask : wptr
    // Issues one instruction and leaves the bench in the cycle that done_q is high.
    task automatic run(input logic [2:0] op, input logic [6:0] ra, input logic ds, input logic ps,
                       input logic [1:0] md, input logic rf, input logic [5:0] ro);
        opCode = bomx_pkg::bomx_op_t'(op);
        regAddr = ra;
        destSel = ds;
        pointerSel = ps;
        pointerUpdateMode = md;
        relativeForm = rf;
        relativeOffset = ro;
        issue = 1'b1;
        @(negedge clk_sys);
        issue = 1'b0;
        chkf("busy", 1'b1, busy);
        @(negedge clk_sys);
        chkf("done", 1'b1, done_q);
    endtask : run
    task automatic xo(input logic [2:0] op, input logic [6:0] ra, input logic ds, input logic [7:0] ma,
                      input logic [7:0] res, input logic c);
        run(op, ra, ds, 1'b0, 2'h0, 1'b0, 6'h00);
        if (ds)
            mem[ma] = res;
        else
            expAcc = res;
        expC = c;
        chkv("acc", expAcc, accumulator_q);
        chkf("zero", res == 8'h00, zeroFlag_q);
        chkf("carry", expC, carryFlag_q);
        memPeekAddr = ma;
        @(negedge clk_sys);
        chkv("mem", mem[ma], memPeekData);
    endtask : xo
    task automatic ld(input logic ps, input logic [1:0] md, input logic rf, input logic [5:0] ro,
                      input logic [7:0] ea, input logic [15:0] ep);
        run(3'h5, 7'h00, 1'b1, ps, md, rf, ro);
        expAcc = mem[ea];
        chkv("acc", expAcc, accumulator_q);
        chkf("zero", expAcc == 8'h00, zeroFlag_q);
        chkf("carry", expC, carryFlag_q);
        chkv("pointer", ep, ps ? pointer1_q : pointer0_q);
    endtask : ld
    task automatic t_arith();
        wmem(8'h10, 8'hFF);
        xo(3'h0, 7'h10, 1'b1, 8'h10, 8'h00, expC);
        xo(3'h0, 7'h10, 1'b0, 8'h10, 8'h01, expC);
        wmem(8'h11, 8'h80);
        xo(3'h1, 7'h11, 1'b0, 8'h11, 8'h81, expC);
        wmem(8'h12, 8'h00);
        xo(3'h4, 7'h12, 1'b0, 8'h12, 8'h00, expC);
        xo(3'h1, 7'h12, 1'b1, 8'h12, 8'h00, expC);
    endtask : t_arith
    task automatic t_shift();
        wmem(8'h13, 8'h81);
        xo(3'h2, 7'h13, 1'b0, 8'h13, 8'h02, 1'b1);
        xo(3'h3, 7'h13, 1'b1, 8'h13, 8'h40, 1'b1);
        wmem(8'h14, 8'h01);
        xo(3'h3, 7'h14, 1'b0, 8'h14, 8'h00, 1'b1);
        wmem(8'h15, 8'h7E);
        xo(3'h2, 7'h15, 1'b1, 8'h15, 8'hFC, 1'b0);
        xo(3'h4, 7'h15, 1'b1, 8'h15, 8'hFC, 1'b0);
        xo(3'h4, 7'h12, 1'b1, 8'h12, 8'h00, 1'b0);
    endtask : t_shift
    task automatic t_indirect();
        wmem(8'h00, 8'h5A);
        wmem(8'hFF, 8'h00);
        wmem(8'h20, 8'h33);
        wmem(8'h21, 8'h44);
        wmem(8'h5F, 8'h66);
        wptr(1'b0, 16'hFFFF);
        wptr(1'b1, 16'h0020);
        ld(1'b0, 2'h0, 1'b0, 6'h00, 8'h00, 16'h0000);
        ld(1'b0, 2'h1, 1'b0, 6'h00, 8'hFF, 16'hFFFF);
        ld(1'b1, 2'h2, 1'b0, 6'h00, 8'h20, 16'h0021);
        ld(1'b1, 2'h3, 1'b0, 6'h00, 8'h21, 16'h0020);
        wptr(1'b1, 16'h0040);
        ld(1'b1, 2'h0, 1'b1, 6'h20, 8'h20, 16'h0040);
        ld(1'b1, 2'h3, 1'b1, 6'h1F, 8'h5F, 16'h0040);
    endtask : t_indirect
    task automatic t_window();
        wptr(1'b0, 16'h0030);
        wptr(1'b1, 16'h0031);
        wmem(8'h30, 8'h77);
        wmem(8'h31, 8'h09);
        xo(3'h4, 7'h00, 1'b0, 8'h30, 8'h77, expC);
        xo(3'h0, 7'h01, 1'b1, 8'h31, 8'h0A, expC);
        chkv("pointer", 16'h0031, pointer1_q);
    endtask : t_window
    // Holds the clock enable low inside an instruction; nothing may move until it returns.
    task automatic t_hold();
        wmem(8'h16, 8'h3C);
        opCode = bomx_pkg::OP_LOGICAL_SHIFT_LEFT;
        regAddr = 7'h16;
        destSel = 1'b0;
        relativeForm = 1'b0;
        issue = 1'b1;
        @(negedge clk_sys);
        issue = 1'b0;
        clkEn = 1'b0;
        repeat (3) @(negedge clk_sys);
        chkf("busy", 1'b1, busy);
        chkf("done", 1'b0, done_q);
        chkv("acc", expAcc, accumulator_q);
        clkEn = 1'b1;
        @(negedge clk_sys);
        expAcc = 8'h78;
        expC = 1'b0;
        chkf("done", 1'b1, done_q);
        chkv("acc", expAcc, accumulator_q);
        chkf("carry", expC, carryFlag_q);
        chkf("zero", 1'b0, zeroFlag_q);
    endtask : t_hold
    initial
    begin
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_arith();
        t_shift();
        t_indirect();
        t_window();
        t_hold();
        summarize();
    end
    initial
    begin
        #100000;
        err_total++;
        summarize();
    end
endmodule : tb
`default_nettype wire

//--- logic/bomx_exec.sv
// Execution datapath for byte operations, register moves and indirect loads.
`timescale 1ns/10ps
`default_nettype none
`include "bomx_map.svh"

module bomx_exec #(
    parameter int MEM_AW = 8
) (
    // Clock, reset and enable.
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              clkEn,
    // Instruction issue.
    input  wire logic              issue,
    input  wire bomx_pkg::bomx_op_t opCode,
    input  wire logic [6:0]        regAddr,
    input  wire logic              destSel,
    input  wire logic              pointerSel,
    input  wire logic [1:0]        pointerUpdateMode,
    input  wire logic              relativeForm,
    input  wire logic [5:0]        relativeOffset,
    // Direct loading of pointers and memory while idle.
    input  wire logic              pointerWrite,
    input  wire logic              pointerWriteSel,
    input  wire logic [15:0]       pointerWriteData,
    input  wire logic              memWrite,
    input  wire logic [MEM_AW-1:0] memWriteAddr,
    input  wire logic [7:0]        memWriteData,
    input  wire logic [MEM_AW-1:0] memPeekAddr,
    // Status and results.
    output logic                   busy,
    output logic                   done_q,
    output logic [7:0]             accumulator_q,
    output logic                   zeroFlag_q,
    output logic                   carryFlag_q,
    output logic [15:0]            pointer0_q,
    output logic [15:0]            pointer1_q,
    output logic [7:0]             memPeekData
);

    logic                 rstSync1_q;
    logic                 rstSyncN_q;
    bomx_pkg::bomx_state_t state_q;
    bomx_pkg::bomx_op_t    op_q;
    logic                 destSel_q;
    logic                 ptrSel_q;
    logic                 ptrUpdate_q;
    logic [15:0]          ptrNext_q;
    logic [MEM_AW-1:0]    effAddr_q;
    logic [15:0]          selPtr;
    logic [15:0]          stepVal;
    logic [15:0]          steppedPtr;
    logic [15:0]          accessPtr;
    logic [MEM_AW-1:0]    effAddr;
    logic                 takeIssue;
    logic                 execNow;
    logic [7:0]           operand;
    logic [7:0]           result;
    logic                 carryNew;
    logic                 carryUpd;
    logic                 memWe;
    logic [MEM_AW-1:0]    memWa;
    logic [7:0]           memWd;
    logic [MEM_AW-1:0]    memRa;

    // A register address that falls on one of the two windows.
    function automatic logic isWindow(input logic [6:0] addr);
        isWindow = (addr == `BOMX_WIN0_ADDR) || (addr == `BOMX_WIN1_ADDR);
    endfunction : isWindow

    // Reset release through two flip-flops.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rstSync1_q <= 1'b0;
            rstSyncN_q <= 1'b0;
        end
        else
        begin
            rstSync1_q <= 1'b1;
            rstSyncN_q <= rstSync1_q;
        end
    end

    assign takeIssue = clkEn && (state_q == bomx_pkg::ST_IDLE) && issue;
    assign execNow   = clkEn && (state_q == bomx_pkg::ST_EXEC);
    assign busy      = (state_q != bomx_pkg::ST_IDLE);

    // Pointer chosen by the index, or by the window for register operands.
    always_comb
    begin
        if (opCode == bomx_pkg::OP_INDIRECT_LOAD_ACCUM)
        begin
            selPtr = pointerSel ? pointer1_q : pointer0_q;
        end
        else
        begin
            selPtr = (regAddr == `BOMX_WIN1_ADDR) ? pointer1_q : pointer0_q;
        end
    end

    // Step arithmetic wraps naturally in 16 bits.
    assign stepVal    = pointerUpdateMode[0] ? `BOMX_PTR_STEP_DOWN : `BOMX_PTR_STEP_UP;
    assign steppedPtr = selPtr + stepVal;

    // Effective address for this instruction.
    always_comb
    begin
        accessPtr = {9'h000, regAddr};
        if (opCode == bomx_pkg::OP_INDIRECT_LOAD_ACCUM)
        begin
            if (relativeForm)
            begin
                accessPtr = selPtr + {{10{relativeOffset[5]}}, relativeOffset};
            end
            else
            begin
                case (pointerUpdateMode)
                    `BOMX_MODE_PREINC,
                    `BOMX_MODE_PREDEC:  accessPtr = steppedPtr;
                    `BOMX_MODE_POSTINC,
                    `BOMX_MODE_POSTDEC: accessPtr = selPtr;
                    default:            accessPtr = selPtr;
                endcase
            end
        end
        else if (isWindow(regAddr))
        begin
            accessPtr = selPtr;
        end
    end

    assign effAddr = accessPtr[MEM_AW-1:0];

    // Instruction capture and the two-clock instruction cycle.
    always_ff @(posedge clk_sys or negedge rstSyncN_q)
    begin
        if (!rstSyncN_q)
        begin
            state_q <= bomx_pkg::ST_IDLE;
        end
        else if (clkEn)
        begin
            case (state_q)
                bomx_pkg::ST_IDLE: if (issue) state_q <= bomx_pkg::ST_EXEC;
                bomx_pkg::ST_EXEC: state_q <= bomx_pkg::ST_IDLE;
                default:           state_q <= bomx_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstSyncN_q)
    begin
        if (!rstSyncN_q)
        begin
            op_q        <= bomx_pkg::OP_MOVE_REGISTER;
            destSel_q   <= `BOMX_DEST_ACC;
            ptrSel_q    <= 1'b0;
            ptrUpdate_q <= 1'b0;
            ptrNext_q   <= `BOMX_PTR_RST;
            effAddr_q   <= '0;
        end
        else if (takeIssue)
        begin
            op_q        <= opCode;
            effAddr_q   <= effAddr;
            ptrNext_q   <= steppedPtr;
            if (opCode == bomx_pkg::OP_INDIRECT_LOAD_ACCUM)
            begin
                destSel_q   <= `BOMX_DEST_ACC;
                ptrSel_q    <= pointerSel;
                ptrUpdate_q <= !relativeForm;
            end
            else
            begin
                destSel_q   <= destSel;
                ptrSel_q    <= (regAddr == `BOMX_WIN1_ADDR);
                ptrUpdate_q <= 1'b0;
            end
        end
    end

    // Result formation from the operand read in the capture clock.
    assign operand = memPeekData;

    always_comb
    begin
        result   = operand;
        carryNew = carryFlag_q;
        carryUpd = 1'b0;
        case (op_q)
            bomx_pkg::OP_INCREMENT_REGISTER:      result = operand + 8'h01;
            bomx_pkg::OP_OR_ACCUMULATOR_REGISTER: result = accumulator_q | operand;
            bomx_pkg::OP_LOGICAL_SHIFT_LEFT:
            begin
                result   = {operand[6:0], 1'b0};
                carryNew = operand[7];
                carryUpd = 1'b1;
            end
            bomx_pkg::OP_LOGICAL_SHIFT_RIGHT:
            begin
                result   = {1'b0, operand[7:1]};
                carryNew = operand[0];
                carryUpd = 1'b1;
            end
            bomx_pkg::OP_MOVE_REGISTER:           result = operand;
            bomx_pkg::OP_INDIRECT_LOAD_ACCUM:     result = operand;
            default:                              result = operand;
        endcase
    end

    // Accumulator write-back.
    always_ff @(posedge clk_sys or negedge rstSyncN_q)
    begin
        if (!rstSyncN_q)
        begin
            accumulator_q <= `BOMX_ACC_RST;
        end
        else if (execNow && (destSel_q == `BOMX_DEST_ACC))
        begin
            accumulator_q <= result;
        end
    end

    // Status flags; pointer stepping never touches them.
    always_ff @(posedge clk_sys or negedge rstSyncN_q)
    begin
        if (!rstSyncN_q)
        begin
            zeroFlag_q  <= `BOMX_FLAG_RST;
            carryFlag_q <= `BOMX_FLAG_RST;
        end
        else if (execNow)
        begin
            zeroFlag_q <= (result == 8'h00);
            if (carryUpd)
            begin
                carryFlag_q <= carryNew;
            end
        end
    end

    // Pointer registers: stepped at the end of a stepping load, or loaded while idle.
    always_ff @(posedge clk_sys or negedge rstSyncN_q)
    begin
        if (!rstSyncN_q)
        begin
            pointer0_q <= `BOMX_PTR_RST;
            pointer1_q <= `BOMX_PTR_RST;
        end
        else if (execNow && ptrUpdate_q)
        begin
            if (ptrSel_q)
            begin
                pointer1_q <= ptrNext_q;
            end
            else
            begin
                pointer0_q <= ptrNext_q;
            end
        end
        else if (clkEn && !busy && !issue && pointerWrite)
        begin
            if (pointerWriteSel)
            begin
                pointer1_q <= pointerWriteData;
            end
            else
            begin
                pointer0_q <= pointerWriteData;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstSyncN_q)
    begin
        if (!rstSyncN_q)
        begin
            done_q <= 1'b0;
        end
        else if (clkEn)
        begin
            done_q <= execNow;
        end
    end

    // Register write-back goes to the redirected address when a window is named.
    always_comb
    begin
        memWe = 1'b0;
        memWa = memWriteAddr;
        memWd = memWriteData;
        if (execNow && (destSel_q == `BOMX_DEST_REG) && (op_q != bomx_pkg::OP_INDIRECT_LOAD_ACCUM))
        begin
            memWe = 1'b1;
            memWa = effAddr_q;
            memWd = result;
        end
        else if (!busy && !issue && memWrite)
        begin
            memWe = 1'b1;
        end
    end

    assign memRa = takeIssue ? effAddr : memPeekAddr;

    bomx_mem #(
        .ADDR_W (MEM_AW)
    ) u_mem (
        .clk_sys  (clk_sys),
        .clkEn    (clkEn),
        .wrEn     (memWe),
        .wrAddr   (memWa),
        .wrData   (memWd),
        .rdAddr   (memRa),
        .rdData_q (memPeekData)
    );

endmodule : bomx_exec

`default_nettype wire

//--- logic/bomx_map.svh
// Constant map for the byte-operation and indirect-load execution block.
`ifndef BOMX_MAP_SVH
`define BOMX_MAP_SVH

`define BOMX_WIN0_ADDR     7'h00
`define BOMX_WIN1_ADDR     7'h01
`define BOMX_MODE_PREINC   2'h0
`define BOMX_MODE_PREDEC   2'h1
`define BOMX_MODE_POSTINC  2'h2
`define BOMX_MODE_POSTDEC  2'h3
`define BOMX_PTR_STEP_UP   16'h0001
`define BOMX_PTR_STEP_DOWN 16'hFFFF
`define BOMX_ACC_RST       8'h00
`define BOMX_PTR_RST       16'h0000
`define BOMX_FLAG_RST      1'b0
`define BOMX_DEST_ACC      1'b0
`define BOMX_DEST_REG      1'b1
`define BOMX_EXEC_CLOCKS   2'h2

`endif

//--- logic/bomx_mem.sv
// Byte-wide data memory with one write port and a registered read port.
`timescale 1ns/10ps
`default_nettype none

module bomx_mem #(
    parameter int ADDR_W = 8
) (
    // Clock and enable.
    input  wire logic              clk_sys,
    input  wire logic              clkEn,
    // Write port.
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [7:0]        wrData,
    // Read port.
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [7:0]        rdData_q
);

    logic [7:0] store [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_sys)
    begin
        if (clkEn && wrEn)
        begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clkEn)
        begin
            rdData_q <= store[rdAddr];
        end
    end

endmodule : bomx_mem

`default_nettype wire

//--- logic/bomx_pkg.sv
// Types shared by the execution block and its bench.
package bomx_pkg;

    typedef enum logic [2:0] {
        OP_INCREMENT_REGISTER      = 3'h0,
        OP_OR_ACCUMULATOR_REGISTER = 3'h1,
        OP_LOGICAL_SHIFT_LEFT      = 3'h2,
        OP_LOGICAL_SHIFT_RIGHT     = 3'h3,
        OP_MOVE_REGISTER           = 3'h4,
        OP_INDIRECT_LOAD_ACCUM     = 3'h5
    } bomx_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_EXEC = 1'h1
    } bomx_state_t;

endpackage : bomx_pkg
